//--- core/adc_ctrl_pkg.sv
// register map, field layout, reset values and timing counts of the
// converter sequencing and window comparator block.
// assumes a 32-bit classic wishbone slave, one register per aligned word.
package adc_ctrl_pkg;

  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [5:0] IDX_CONTROL  = 6'h00;
  localparam logic [5:0] IDX_WINMODE  = 6'h04;
  localparam logic [5:0] IDX_SAMPLE_LENGTH_EXTENSION  = 6'h05;
  localparam logic [5:0] IDX_INSEL    = 6'h06;
  localparam logic [5:0] IDX_COMMAND  = 6'h08;
  localparam logic [5:0] IDX_EVENT    = 6'h09;
  localparam logic [5:0] IDX_INTEN    = 6'h0a;
  localparam logic [5:0] IDX_FLAGS    = 6'h0b;
  localparam logic [5:0] IDX_DEBUG    = 6'h0c;
  localparam logic [5:0] IDX_RESULT   = 6'h10;
  localparam logic [5:0] IDX_WINLO    = 6'h12;
  localparam logic [5:0] IDX_WINHI    = 6'h14;

  // ==========================================================
  // field positions
  localparam int POS_ENABLE    = 0;
  localparam int POS_CONT      = 1;
  localparam int POS_ACCNUM    = 4;
  localparam int POS_START_CONVERSION_BIT    = 0;
  localparam int POS_EVSTART   = 0;
  localparam int POS_RUN_DURING_DEBUG_HALT    = 0;
  localparam int POS_RESULT_READY_FLAG    = 0;
  localparam int POS_WINDOW_MATCH_FLAG     = 1;

  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [4:0]  RST_MUX   = 5'h00;
  localparam logic [2:0]  RST_MODE  = 3'h0;

  // ==========================================================
  // window modes, codes above OUTSIDE are reserved
  localparam logic [2:0] WIN_NONE    = 3'h0;
  localparam logic [2:0] WIN_BELOW   = 3'h1;
  localparam logic [2:0] WIN_ABOVE   = 3'h2;
  localparam logic [2:0] WIN_INSIDE  = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;

  // ==========================================================
  // timing counts in peripheral clocks and converter clocks
  localparam logic [7:0] ADC_DIV      = 8'h04;
  localparam logic [5:0] SAMP_BASE    = 6'h02;
  localparam logic [5:0] CONV_TICKS   = 6'h0a;
  localparam logic [2:0] ACC_MAX_LOG  = 3'h6;
  localparam logic [15:0] ACC_CEILING = 16'hffc0;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11
  } conv_state_t;

endpackage

//--- core/adc_seq_window.sv
// control logic of a 10-bit successive-approximation converter: channel
// latch, sample length, start sources, accumulation, window compare, flags.
// assumes a classic wishbone master on 32-bit data, a 10-bit sample word
// valid at the end of each conversion phase, and an event pulse input.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - window mode selects none, below, above, strictly inside or outside; others reserved
// - the window compares the full 16-bit accumulated result
// - sampling lasts two converter clocks plus the programmed extension
// - extra sampling clocks push the end of conversion later
// - input select routes pins 0-3, 6, 7, reference, sensor or ground
// - a new input select takes effect only after the running conversion
// - writing one to start launches one conversion, or the first when continuous
// - start bit reads one while busy and clears itself on completion
// - with event start enabled an event starts a conversion like software
// - enable bit 1 gates window interrupt, bit 0 gates result interrupt
// - at conversion end the window flag is set only on a match
// - window flag clears by writing one or reading the result; zero ignored
// - result ready flag sets whenever a new result is available
// - result ready flag clears by writing one or reading the result
// - without debug run the converter halts and ignores events in debug break
// - with debug run the converter keeps working during debug break
// - continuous mode starts the next conversion as the previous completes
// - thresholds apply once to the accumulated total, not each sample
// - the sample count saturates at 64, so the total is never above 0xffc0
module adc_seq_window
  import adc_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [9:0]  sampleData,
  input  wire logic        eventIn,
  input  wire logic        debugHalt,
  output logic      [4:0]  channelSel,
  output logic             samplingActive,
  output logic             conversionDone,
  output logic             irq
);

  // ==========================================================
  // state
  typedef struct packed {
    conv_state_t st;
    logic [7:0]  divCnt;
    logic [5:0]  phaseCnt;
    logic [6:0]  smpCnt;
    logic [15:0] acc;
    logic [15:0] result;
    logic        enable;
    logic        contMode;
    logic [2:0]  accNum;
    logic [2:0]  winMode;
    logic [4:0]  sample_length_extension;
    logic [4:0]  muxSel;
    logic [4:0]  chanSel;
    logic        evStartEn;
    logic [1:0]  intEn;
    logic [1:0]  flags;
    logic        run_during_debug_halt;
    logic [15:0] winLo;
    logic [15:0] winHi;
    logic        ack;
    logic [31:0] rdat;
    logic        irq;
    logic        sampling;
    logic        done;
  } state_t;

  localparam state_t RESET_STATE = '{
    st: ST_IDLE, divCnt: RST_BYTE, phaseCnt: 6'h00, smpCnt: 7'h00,
    acc: RST_WORD, result: RST_WORD, enable: 1'b0, contMode: 1'b0,
    accNum: RST_MODE, winMode: RST_MODE, sample_length_extension: RST_MUX, muxSel: RST_MUX,
    chanSel: RST_MUX, evStartEn: 1'b0, intEn: 2'h0, flags: 2'h0,
    run_during_debug_halt: 1'b0, winLo: RST_WORD, winHi: RST_WORD, ack: 1'b0,
    rdat: 32'h0000_0000, irq: 1'b0, sampling: 1'b0, done: 1'b0};

  state_t q;
  state_t d;

  // ==========================================================
  // window compare on the 16-bit total
  function automatic logic win_hit(input logic [2:0]  mode,
                                   input logic [15:0] res,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    case (mode)
      WIN_BELOW:   win_hit = res < lo;
      WIN_ABOVE:   win_hit = res > hi;
      WIN_INSIDE:  win_hit = (res > lo) && (res < hi);
      WIN_OUTSIDE: win_hit = (res < lo) || (res > hi);
      default:     win_hit = 1'b0;
    endcase
  endfunction

  logic        halted;
  logic        access;
  logic        wrAcc;
  logic        rdAcc;
  logic [5:0]  idx;
  logic        busy;
  logic        swStart;
  logic        evStart;
  logic        tick;
  logic [5:0]  sampEnd;
  logic [15:0] total;
  logic [6:0]  needed;
  logic [2:0]  accLog;
  logic        lastSmp;
  logic        hit;
  logic [1:0]  setFlags;

  always_comb begin
    halted  = debugHalt & ~q.run_during_debug_halt;
    access  = wb_cyc_i & wb_stb_i & ~q.ack;
    wrAcc   = access & wb_we_i;
    rdAcc   = access & ~wb_we_i;
    idx     = wb_adr_i[7:2];
    busy    = q.st != ST_IDLE;
    tick    = q.divCnt == (ADC_DIV - 8'h01);
    sampEnd = {1'b0, q.sample_length_extension} + SAMP_BASE - 6'h01;
    total   = q.acc + {6'h00, sampleData};
    accLog  = (q.accNum > ACC_MAX_LOG) ? ACC_MAX_LOG : q.accNum;
    needed  = 7'h01 << accLog;
    lastSmp = q.smpCnt == (needed - 7'h01);
    hit     = win_hit(q.winMode, total, q.winLo, q.winHi);
    swStart = wrAcc & (idx == IDX_COMMAND) & wb_sel_i[0]
              & wb_dat_i[POS_START_CONVERSION_BIT];
    evStart = eventIn & q.evStartEn;
    setFlags = 2'h0;

    d       = q;
    d.ack   = access;
    d.done  = 1'b0;
    d.rdat  = 32'h0000_0000;

    // ========================================================
    // register writes
    if (wrAcc && wb_sel_i[0]) begin
      case (idx)
        IDX_CONTROL: begin
          d.enable   = wb_dat_i[POS_ENABLE];
          d.contMode = wb_dat_i[POS_CONT];
          d.accNum   = wb_dat_i[POS_ACCNUM +: 3];
        end
        IDX_WINMODE: d.winMode   = wb_dat_i[2:0];
        IDX_SAMPLE_LENGTH_EXTENSION: d.sample_length_extension   = wb_dat_i[4:0];
        IDX_INSEL:   d.muxSel    = wb_dat_i[4:0];
        IDX_EVENT:   d.evStartEn = wb_dat_i[POS_EVSTART];
        IDX_INTEN:   d.intEn     = wb_dat_i[1:0];
        IDX_FLAGS:   d.flags     = q.flags & ~wb_dat_i[1:0];
        IDX_DEBUG:   d.run_during_debug_halt    = wb_dat_i[POS_RUN_DURING_DEBUG_HALT];
        IDX_WINLO:   d.winLo[7:0] = wb_dat_i[7:0];
        IDX_WINHI:   d.winHi[7:0] = wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
    if (wrAcc && wb_sel_i[1]) begin
      if (idx == IDX_WINLO) begin
        d.winLo[15:8] = wb_dat_i[15:8];
      end
      if (idx == IDX_WINHI) begin
        d.winHi[15:8] = wb_dat_i[15:8];
      end
    end

    // ========================================================
    // register reads; reading the result drops both flags
    if (rdAcc) begin
      case (idx)
        IDX_CONTROL: d.rdat = {25'h0, q.accNum, 2'h0, q.contMode, q.enable};
        IDX_WINMODE: d.rdat = {29'h0, q.winMode};
        IDX_SAMPLE_LENGTH_EXTENSION: d.rdat = {27'h0, q.sample_length_extension};
        IDX_INSEL:   d.rdat = {27'h0, q.muxSel};
        IDX_COMMAND: d.rdat = {31'h0, busy};
        IDX_EVENT:   d.rdat = {31'h0, q.evStartEn};
        IDX_INTEN:   d.rdat = {30'h0, q.intEn};
        IDX_FLAGS:   d.rdat = {30'h0, q.flags};
        IDX_DEBUG:   d.rdat = {31'h0, q.run_during_debug_halt};
        IDX_RESULT: begin
          d.rdat  = {16'h0, q.result};
          d.flags = 2'h0;
        end
        IDX_WINLO:   d.rdat = {16'h0, q.winLo};
        IDX_WINHI:   d.rdat = {16'h0, q.winHi};
        default:     d.rdat = 32'h0000_0000;
      endcase
    end

    // ========================================================
    // conversion sequencer, frozen while halted in debug break
    if (!halted) begin
      if (busy) begin
        d.divCnt = tick ? 8'h00 : q.divCnt + 8'h01;
      end
      case (q.st)
        ST_IDLE: begin
          // channel latched here so later select writes wait
          if (q.enable && (swStart || evStart)) begin
            d.st       = ST_SAMPLE;
            d.chanSel  = d.muxSel;
            d.acc      = RST_WORD;
            d.smpCnt   = 7'h00;
            d.phaseCnt = 6'h00;
            d.divCnt   = 8'h00;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (q.phaseCnt >= sampEnd) begin
              d.phaseCnt = 6'h00;
              d.st       = ST_CONVERT;
            end else begin
              d.phaseCnt = q.phaseCnt + 6'h01;
            end
          end
        end
        ST_CONVERT: begin
          if (tick && q.phaseCnt == (CONV_TICKS - 6'h01)) begin
            d.phaseCnt = 6'h00;
            d.smpCnt   = q.smpCnt + 7'h01;
            if (lastSmp) begin
              d.result      = total;
              d.done        = 1'b1;
              setFlags[POS_RESULT_READY_FLAG] = 1'b1;
              setFlags[POS_WINDOW_MATCH_FLAG]  = hit;
              d.acc         = RST_WORD;
              d.smpCnt      = 7'h00;
              if (q.contMode) begin
                d.st      = ST_SAMPLE;
                d.chanSel = d.muxSel;
              end else begin
                d.st = ST_IDLE;
              end
            end else begin
              d.acc = total;
              d.st  = ST_SAMPLE;
            end
          end else if (tick) begin
            d.phaseCnt = q.phaseCnt + 6'h01;
          end
        end
        default: d.st = ST_IDLE;
      endcase
    end

    // set wins over a clear in the same cycle
    d.flags    = d.flags | setFlags;
    d.sampling = d.st == ST_SAMPLE;
    d.irq      = |(d.flags & d.intEn);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= RESET_STATE;
    end else if (ce) begin
      q <= d;
    end
  end

  assign wb_dat_o       = q.rdat;
  assign wb_ack_o       = q.ack;
  assign channelSel     = q.chanSel;
  assign samplingActive = q.sampling;
  assign conversionDone = q.done;
  assign irq            = q.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_lastPhase;
    ce && !halted && q.st == ST_CONVERT && tick && lastSmp
      && q.phaseCnt == (CONV_TICKS - 6'h01);
  endsequence

  sequence s_sampleEnd;
    ce && !halted && q.st == ST_SAMPLE && tick && q.phaseCnt == sampEnd;
  endsequence

  // a read of the result in the completion cycle may clear an old flag,
  // so only demand the set when the finished total matched
  a_window_set: assert property (
    s_lastPhase |=> q.done && (q.flags[POS_WINDOW_MATCH_FLAG] || !$past(hit)))
    else $error("window flag not set on a match at completion");

  a_window_cause: assert property (
    $rose(q.flags[POS_WINDOW_MATCH_FLAG]) |-> $past(hit) && $past(q.winMode) != WIN_NONE
                                  && $past(q.winMode) <= WIN_OUTSIDE)
    else $error("window flag rose without a matching mode");

  a_ready_set: assert property (
    s_lastPhase |=> q.flags[POS_RESULT_READY_FLAG] && q.result == $past(total))
    else $error("result ready or result missing after completion");

  a_flag_wclear: assert property (
    ce && wrAcc && idx == IDX_FLAGS && wb_sel_i[0] && wb_dat_i[1:0] == 2'h3
    && !(q.st == ST_CONVERT && tick) |=> q.flags == 2'h0)
    else $error("write one did not clear flags");

  a_flag_rdclear: assert property (
    ce && rdAcc && idx == IDX_RESULT && !(q.st == ST_CONVERT && tick)
    |=> q.flags == 2'h0)
    else $error("result read did not clear flags");

  a_sample_length: assert property (
    s_sampleEnd |=> q.st == ST_CONVERT && q.phaseCnt == 6'h00)
    else $error("sampling phase did not end at programmed length");

  a_sample_bound: assert property (
    q.st == ST_SAMPLE |-> q.phaseCnt <= sampEnd || $past(q.sample_length_extension) != q.sample_length_extension)
    else $error("sampling phase ran past its length");

  a_channel_hold: assert property (
    busy && $past(busy) && !$past(q.done) && !q.done |-> $stable(q.chanSel))
    else $error("channel changed during a conversion");

  a_event_start: assert property (
    ce && !busy && q.enable && !halted && evStart |=> busy ##0 q.st == ST_SAMPLE)
    else $error("event did not start a conversion");

  a_halt_freeze: assert property (
    ce && halted && busy |=> $stable(q.st) && $stable(q.phaseCnt) && $stable(q.acc))
    else $error("sequencer moved during debug halt");

  a_busy_read: assert property (
    ce && rdAcc && idx == IDX_COMMAND |=> wb_dat_o[POS_START_CONVERSION_BIT] == $past(busy))
    else $error("start bit read back wrong");

  a_cont_next: assert property (
    s_lastPhase ##0 q.contMode |=> q.st == ST_SAMPLE)
    else $error("continuous mode did not restart");

  a_acc_bound: assert property (
    q.acc <= ACC_CEILING && q.result <= ACC_CEILING)
    else $error("accumulated value above ceiling");

  a_irq_level: assert property (
    irq == |(q.flags & q.intEn))
    else $error("interrupt request disagrees with flags");

endmodule

`default_nettype wire

//--- tb/tb_adc_seq_window.sv
// self-checking bench for the converter sequencing and window compare block.
// assumes the package register map and the hand-over timing: 4 clk per
// converter tick, registered ack one cycle after the request is taken.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_seq_window
  import adc_ctrl_pkg::*;
;
  logic        clk;
  logic        srst;
  logic        ce;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic [9:0]  sampleData;
  logic        eventIn;
  logic        debugHalt;
  logic [4:0]  channelSel;
  logic        samplingActive;
  logic        conversionDone;
  logic        irq;
  int          nMismatch;
  int          checksDone;

  adc_seq_window adc_seq_window_inst (
    .clk(clk), .srst(srst), .ce(ce), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .sampleData(sampleData), .eventIn(eventIn),
    .debugHalt(debugHalt), .channelSel(channelSel), .samplingActive(samplingActive),
    .conversionDone(conversionDone), .irq(irq)
  );

  // ==========================================================
  // clock, verdict and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // longest expected run is near 11k cycles, so 80k leaves ample margin
  initial begin
    #400000;
    nMismatch++;
    complete_run();
  end

  // ==========================================================
  // bus and comparison tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= {idx, 2'b00};
    wbDatI <= wd;
    wbSel  <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 100);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    check("bus ack", {31'h0, wbAck}, 32'h1);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [31:0] e, input string nm);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, d);
    check(nm, d, e);
  endtask

  // counts cycles to the end pulse and how many of them were sampling
  task automatic waitDone(output int dur, output int samp);
    dur  = 0;
    samp = 0;
    // start is taken one edge before the ack, so its first sampling clock shows now
    if (samplingActive === 1'b1) samp++;
    do begin
      @(posedge clk);
      dur++;
      if (samplingActive === 1'b1) samp++;
    end while (conversionDone !== 1'b1 && dur < 20000);
    check("conversion end", {31'h0, conversionDone}, 32'h1);
  endtask

  task automatic conv(input logic [9:0] s, output int dur, output int samp);
    sampleData <= s;
    wr(IDX_COMMAND, 32'h1);
    waitDone(dur, samp);
  endtask

  task automatic pulseEvent();
    @(posedge clk);
    eventIn <= 1'b1;
    @(posedge clk);
    eventIn <= 1'b0;
  endtask

  function automatic logic winExp(input logic [2:0] m, input logic [15:0] r,
                                  input logic [15:0] lo, input logic [15:0] hi);
    case (m)
      3'h1:    return r < lo;
      3'h2:    return r > hi;
      3'h3:    return (r > lo) && (r < hi);
      3'h4:    return (r < lo) || (r > hi);
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // test sequence
  initial begin
    static logic [5:0]  rstIdx [7] = '{IDX_SAMPLE_LENGTH_EXTENSION, IDX_INSEL, IDX_COMMAND, IDX_EVENT,
                                       IDX_INTEN, IDX_FLAGS, IDX_DEBUG};
    static logic [4:0]  codes [9]  = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07,
                                       5'h1d, 5'h1e, 5'h1f};
    static logic [9:0]  vals [4]   = '{10'h0c0, 10'h100, 10'h200, 10'h3ff};
    logic [15:0] tot;
    logic        we;
    int          d0, s0, d1, s1;
    srst = 1'b1; ce = 1'b1; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0;
    wbAdr = 8'h00; wbSel = 4'h0; wbDatI = 32'h0; sampleData = 10'h000;
    eventIn = 1'b0; debugHalt = 1'b0; nMismatch = 0; checksDone = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    foreach (rstIdx[i]) rdc(rstIdx[i], 32'h0, "reset value");
    wr(6'h3f, 32'hffffffff);
    rdc(6'h3f, 32'h0, "unmapped read");
    // sample length and duration
    wr(IDX_CONTROL, 32'h1);
    conv(10'h3ff, d0, s0);
    check("sampling clocks ext 0", s0, 32'd8);
    rdc(IDX_FLAGS, 32'h1, "ready flag set");
    wr(IDX_FLAGS, 32'h0);
    rdc(IDX_FLAGS, 32'h1, "ready flag kept");
    rdc(IDX_COMMAND, 32'h0, "start cleared");
    wr(IDX_FLAGS, 32'h1);
    rdc(IDX_FLAGS, 32'h0, "ready flag w1c");
    wr(IDX_SAMPLE_LENGTH_EXTENSION, 32'h3);
    conv(10'h3ff, d1, s1);
    check("sampling clocks ext 3", s1, 32'd20);
    check("duration growth", d1 - d0, 32'd12);
    wr(IDX_SAMPLE_LENGTH_EXTENSION, 32'h1f);
    conv(10'h3ff, d1, s1);
    check("sampling clocks ext 31", s1, 32'd132);
    wr(IDX_SAMPLE_LENGTH_EXTENSION, 32'h0);
    // input select routing and latching
    wr(IDX_INSEL, 32'hff);
    rdc(IDX_INSEL, 32'h1f, "select read-only bits");
    foreach (codes[i]) begin
      wr(IDX_INSEL, {27'h0, codes[i]});
      rdc(IDX_INSEL, {27'h0, codes[i]}, "select readback");
      wr(IDX_COMMAND, 32'h1);
      wr(IDX_INSEL, {27'h0, ~codes[i]});
      check("channel held", {27'h0, channelSel}, {27'h0, codes[i]});
      rdc(IDX_COMMAND, 32'h1, "busy reads one");
      waitDone(d1, s1);
    end
    // window compare on a four-sample total, edges at the thresholds
    wr(IDX_CONTROL, 32'h21);
    wr(IDX_WINLO, 32'h0400);
    wr(IDX_WINHI, 32'h0800);
    wr(IDX_INTEN, 32'h2);
    for (int m = 0; m < 8; m++) begin
      wr(IDX_WINMODE, m);
      foreach (vals[j]) begin
        tot = {6'h0, vals[j]} << 2;
        we = winExp(m[2:0], tot, 16'h0400, 16'h0800);
        conv(vals[j], d1, s1);
        rdc(IDX_FLAGS, {30'h0, we, 1'b1}, "window flag");
        check("irq window", {31'h0, irq}, {31'h0, we});
        rdc(IDX_RESULT, {16'h0, tot}, "result total");
        rdc(IDX_FLAGS, 32'h0, "flags cleared by result read");
        check("irq dropped", {31'h0, irq}, 32'h0);
      end
    end
    // ready interrupt enable
    wr(IDX_INTEN, 32'h1);
    conv(10'h001, d1, s1);
    check("irq ready", {31'h0, irq}, 32'h1);
    wr(IDX_INTEN, 32'h0);
    @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(IDX_FLAGS, 32'h3);
    // saturated 64-sample total
    wr(IDX_CONTROL, 32'h61);
    conv(10'h3ff, d1, s1);
    rdc(IDX_RESULT, 32'hffc0, "saturated total");
    // event start
    wr(IDX_CONTROL, 32'h1);
    pulseEvent();
    repeat (10) @(posedge clk);
    rdc(IDX_COMMAND, 32'h0, "event disabled");
    wr(IDX_EVENT, 32'h1);
    pulseEvent();
    rdc(IDX_COMMAND, 32'h1, "event started");
    waitDone(d1, s1);
    // debug break
    debugHalt <= 1'b1;
    pulseEvent();
    repeat (10) @(posedge clk);
    rdc(IDX_COMMAND, 32'h0, "event ignored in halt");
    // a running conversion must stand still through a long break
    debugHalt <= 1'b0;
    wr(IDX_COMMAND, 32'h1);
    debugHalt <= 1'b1;
    repeat (100) @(posedge clk);
    rdc(IDX_COMMAND, 32'h1, "frozen in halt");
    debugHalt <= 1'b0;
    waitDone(d1, s1);
    debugHalt <= 1'b1;
    wr(IDX_DEBUG, 32'h1);
    rdc(IDX_DEBUG, 32'h1, "debug run readback");
    pulseEvent();
    rdc(IDX_COMMAND, 32'h1, "event runs in halt");
    waitDone(d1, s1);
    debugHalt <= 1'b0;
    // continuous mode: one start, back-to-back completions
    wr(IDX_CONTROL, 32'h3);
    wr(IDX_COMMAND, 32'h1);
    waitDone(d1, s1);
    waitDone(d1, s1);
    rdc(IDX_COMMAND, 32'h1, "busy in continuous");
    wr(IDX_CONTROL, 32'h1);
    waitDone(d1, s1);
    repeat (4) @(posedge clk);
    rdc(IDX_COMMAND, 32'h0, "continuous stopped");
    complete_run();
  end
endmodule
`default_nettype wire
